// ===== pkg/olsb_pkg.sv
package olsb_pkg;

  // Serial frame
  localparam int unsigned FRAME_BITS      = 16;
  localparam int unsigned BYTE_BITS       = 8;
  localparam logic [4:0]  CNT_ADDR_LAST   = 5'h07;
  localparam logic [4:0]  CNT_DATA_FIRST  = 5'h08;
  localparam logic [4:0]  CNT_FRAME_DONE  = 5'h10;

  // Address byte: [access_kind_bit] 010 01 [frame_flag_bit] 1
  localparam int unsigned ADDR_KIND_POS   = 7;
  localparam int unsigned ADDR_SEL_HI     = 6;
  localparam int unsigned ADDR_SEL_LO     = 2;
  localparam int unsigned ADDR_FRAME_POS  = 1;
  localparam int unsigned ADDR_TAIL_POS   = 0;
  localparam logic [4:0]  ADDR_SEL_UPPER  = 5'h09;
  localparam logic        ADDR_TAIL_VAL   = 1'b1;

  // Field positions of open_load_status_bridges_9_to_12
  localparam int unsigned BRIDGE12_HIGH   = 7;
  localparam int unsigned BRIDGE12_LOW    = 6;
  localparam int unsigned BRIDGE11_HIGH   = 5;
  localparam int unsigned BRIDGE11_LOW    = 4;
  localparam int unsigned BRIDGE10_HIGH   = 3;
  localparam int unsigned BRIDGE10_LOW    = 2;
  localparam int unsigned BRIDGE9_HIGH    = 1;
  localparam int unsigned BRIDGE9_LOW     = 0;

  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  // Outputs that exist in this variant; absent ones stay reserved at zero
  localparam logic [7:0]  PRESENT_MASK    = 8'hff;

  // Status byte sent during the address byte
  localparam int unsigned GLOBAL_ERR_POS  = 7;

  typedef logic [7:0] olsb_byte_t;

endpackage : olsb_pkg

// ===== core/olsb_flag_bank.sv
`timescale 1ns/1ps
module olsb_flag_bank (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire olsb_pkg::olsb_byte_t detect,
  input  wire logic              clear,
  input  wire olsb_pkg::olsb_byte_t clear_mask,
  output olsb_pkg::olsb_byte_t   flags_r
);
  import olsb_pkg::*;

  olsb_byte_t set_bits;
  olsb_byte_t flags_nxt;

  always_comb begin
    set_bits  = detect & PRESENT_MASK; // R8
    flags_nxt = flags_r;
    if (clear) begin
      flags_nxt = flags_r & ~clear_mask; // R7
    end
    // Set wins over a clear in the same cycle
    flags_nxt = (flags_nxt | set_bits) & PRESENT_MASK; // R6 R9
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_r <= STATUS_RESET; // R7
    end else begin
      flags_r <= flags_nxt;
    end
  end

  a_flag_latched: assert property ( // R6
    @(posedge clock) disable iff (!reset_n)
    !clear |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("Latched flag dropped without a clear");

  a_clear_zero: assert property ( // R7
    @(posedge clock) disable iff (!reset_n)
    (clear && detect == 8'h00) |=> ((flags_r & $past(clear_mask)) == 8'h00))
    else $error("Cleared flag did not return to zero");

  a_reserved_zero: assert property ( // R8
    @(posedge clock) disable iff (!reset_n)
    (flags_r & ~PRESENT_MASK) == 8'h00)
    else $error("Reserved flag bit is not zero");

  a_set_wins: assert property ( // R9
    @(posedge clock) disable iff (!reset_n)
    (clear && (detect & PRESENT_MASK) != 8'h00)
      |=> ((flags_r & $past(detect & PRESENT_MASK))
           == $past(detect & PRESENT_MASK)))
    else $error("Detection lost against a clearing read");

endmodule : olsb_flag_bank

// ===== core/olsb_status_upper.sv
`timescale 1ns/1ps
//Contract
// R1 - Address byte middle bits 010 01, then frame flag bit, last bit 1.
// R2 - D7 is bridge 12 high-side open flag, D6 its low-side flag.
// R3 - D5 is bridge 11 high-side open flag, D4 its low-side flag.
// R4 - D3 is bridge 10 high-side open flag, D2 its low-side flag.
// R5 - D1 is bridge 9 high-side open flag, D0 its low-side flag.
// R6 - Detected open load sets flag to 1; it stays until read clears it.
// R7 - Flags are 0 after reset and return to 0 when cleared.
// R8 - Flags of absent outputs are reserved and always read 0.
// R9 - One-cycle detect pulse sets flag; set beats a coincident clearing read.
module olsb_status_upper (
  input  wire logic            clock,
  input  wire logic            reset_n,
  input  wire logic            spi_cs_n,
  input  wire logic            spi_sclk,
  input  wire logic            spi_sdi,
  output logic                 spi_sdo_out_r,
  output logic                 spi_sdo_oe_r,
  input  wire logic            bridge12_high_open_det,
  input  wire logic            bridge12_low_open_det,
  input  wire logic            bridge11_high_open_det,
  input  wire logic            bridge11_low_open_det,
  input  wire logic            bridge10_high_open_det,
  input  wire logic            bridge10_low_open_det,
  input  wire logic            bridge9_high_open_det,
  input  wire logic            bridge9_low_open_det,
  output olsb_pkg::olsb_byte_t open_load_status_upper
);
  import olsb_pkg::*;

  function automatic logic addr_match(input olsb_byte_t a);
    addr_match = (a[ADDR_SEL_HI:ADDR_SEL_LO] == ADDR_SEL_UPPER)
                 && (a[ADDR_TAIL_POS] == ADDR_TAIL_VAL); // R1
  endfunction : addr_match

  // Pin synchronisers: level accepted once stages two and three agree
  logic [2:0]  cs_sync_r;
  logic [2:0]  sclk_sync_r;
  logic [2:0]  sdi_sync_r;
  logic        cs_lvl_r;
  logic        sclk_lvl_r;
  logic        sdi_lvl_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cs_sync_r   <= 3'h7;
      sclk_sync_r <= 3'h0;
      sdi_sync_r  <= 3'h0;
    end else begin
      cs_sync_r   <= {cs_sync_r[1:0], spi_cs_n};
      sclk_sync_r <= {sclk_sync_r[1:0], spi_sclk};
      sdi_sync_r  <= {sdi_sync_r[1:0], spi_sdi};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cs_lvl_r   <= 1'b1;
      sclk_lvl_r <= 1'b0;
      sdi_lvl_r  <= 1'b0;
    end else begin
      if (cs_sync_r[1] == cs_sync_r[2]) begin
        cs_lvl_r <= cs_sync_r[2];
      end
      if (sclk_sync_r[1] == sclk_sync_r[2]) begin
        sclk_lvl_r <= sclk_sync_r[2];
      end
      if (sdi_sync_r[1] == sdi_sync_r[2]) begin
        sdi_lvl_r <= sdi_sync_r[2];
      end
    end
  end

  logic cs_new;
  logic sclk_new;
  logic frame_start;
  logic frame_end;
  logic sclk_rise;
  logic sclk_fall;

  always_comb begin
    cs_new   = (cs_sync_r[1] == cs_sync_r[2]) ? cs_sync_r[2] : cs_lvl_r;
    sclk_new = (sclk_sync_r[1] == sclk_sync_r[2]) ? sclk_sync_r[2]
                                                  : sclk_lvl_r;
    frame_start = cs_lvl_r && !cs_new;
    frame_end   = !cs_lvl_r && cs_new;
    sclk_rise   = !cs_lvl_r && !sclk_lvl_r && sclk_new;
    sclk_fall   = !cs_lvl_r && sclk_lvl_r && !sclk_new;
  end

  // Detector pulses in register bit order
  olsb_byte_t det_vec;

  always_comb begin
    det_vec                = 8'h00;
    det_vec[BRIDGE12_HIGH] = bridge12_high_open_det; // R2
    det_vec[BRIDGE12_LOW]  = bridge12_low_open_det; // R2
    det_vec[BRIDGE11_HIGH] = bridge11_high_open_det; // R3
    det_vec[BRIDGE11_LOW]  = bridge11_low_open_det; // R3
    det_vec[BRIDGE10_HIGH] = bridge10_high_open_det; // R4
    det_vec[BRIDGE10_LOW]  = bridge10_low_open_det; // R4
    det_vec[BRIDGE9_HIGH]  = bridge9_high_open_det; // R5
    det_vec[BRIDGE9_LOW]   = bridge9_low_open_det; // R5
  end

  // Frame receiver
  logic [4:0]  bit_cnt_r;
  logic [15:0] rx_r;
  logic        addr_hit_r;
  olsb_byte_t  snap_r;
  logic        clear_r;
  olsb_byte_t  clear_mask_r;
  olsb_byte_t  addr_byte;

  assign addr_byte = {rx_r[BYTE_BITS-2:0], sdi_lvl_r};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_r  <= 5'h00;
      rx_r       <= 16'h0000;
      addr_hit_r <= 1'b0;
      snap_r     <= STATUS_RESET;
    end else if (frame_start) begin
      bit_cnt_r  <= 5'h00;
      addr_hit_r <= 1'b0;
      snap_r     <= STATUS_RESET;
    end else if (sclk_rise) begin
      rx_r <= {rx_r[FRAME_BITS-2:0], sdi_lvl_r};
      if (bit_cnt_r != CNT_FRAME_DONE + 5'h01) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
      if (bit_cnt_r == CNT_ADDR_LAST) begin
        addr_hit_r <= addr_match(addr_byte); // R1
        // Snapshot is what the host sees and what gets cleared
        snap_r <= addr_match(addr_byte) ? open_load_status_upper
                                        : STATUS_RESET;
      end
    end
  end

  // Read-to-clear on a complete frame only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clear_r      <= 1'b0;
      clear_mask_r <= STATUS_RESET;
    end else begin
      clear_r      <= frame_end && addr_hit_r
                      && (bit_cnt_r == CNT_FRAME_DONE); // R6
      clear_mask_r <= snap_r;
    end
  end

  olsb_flag_bank u_flags (
    .clock      (clock),
    .reset_n    (reset_n),
    .detect     (det_vec),
    .clear      (clear_r),
    .clear_mask (clear_mask_r),
    .flags_r    (open_load_status_upper)
  );

  // Transmitter: status byte, then register byte, MSB first
  logic [15:0] tx_r;
  olsb_byte_t  status_byte;

  always_comb begin
    status_byte = 8'h00;
    status_byte[GLOBAL_ERR_POS] = |open_load_status_upper;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_r          <= 16'h0000;
      spi_sdo_out_r <= 1'b0;
      spi_sdo_oe_r  <= 1'b0;
    end else if (frame_end) begin
      spi_sdo_oe_r  <= 1'b0;
      spi_sdo_out_r <= 1'b0;
    end else if (frame_start) begin
      spi_sdo_oe_r  <= 1'b1;
      tx_r          <= {status_byte, 8'h00};
      spi_sdo_out_r <= status_byte[GLOBAL_ERR_POS];
    end else if (sclk_fall) begin
      if (bit_cnt_r == CNT_DATA_FIRST) begin
        tx_r          <= {snap_r, 8'h00};
        spi_sdo_out_r <= snap_r[BYTE_BITS-1];
      end else begin
        tx_r          <= {tx_r[FRAME_BITS-2:0], 1'b0};
        spi_sdo_out_r <= tx_r[FRAME_BITS-2];
      end
    end
  end

  a_addr_decode: assert property ( // R1
    @(posedge clock) disable iff (!reset_n)
    (!frame_start && sclk_rise && bit_cnt_r == CNT_ADDR_LAST)
      |=> (addr_hit_r == addr_match($past(addr_byte))))
    else $error("Address byte decode mismatch");

  a_b12_map: assert property ( // R2
    @(posedge clock) disable iff (!reset_n)
    (bridge12_high_open_det && bridge12_low_open_det)
      |=> (open_load_status_upper[BRIDGE12_HIGH]
           && open_load_status_upper[BRIDGE12_LOW]))
    else $error("Bridge 12 flag not at its bit");

  a_b11_map: assert property ( // R3
    @(posedge clock) disable iff (!reset_n)
    bridge11_high_open_det |=> open_load_status_upper[BRIDGE11_HIGH])
    else $error("Bridge 11 high flag not at its bit");

  a_b11_low: assert property ( // R3
    @(posedge clock) disable iff (!reset_n)
    bridge11_low_open_det |=> open_load_status_upper[BRIDGE11_LOW])
    else $error("Bridge 11 low flag not at its bit");

  a_b10_map: assert property ( // R4
    @(posedge clock) disable iff (!reset_n)
    (bridge10_high_open_det && bridge10_low_open_det)
      |=> (open_load_status_upper[BRIDGE10_HIGH]
           && open_load_status_upper[BRIDGE10_LOW]))
    else $error("Bridge 10 flag not at its bit");

  a_b9_map: assert property ( // R5
    @(posedge clock) disable iff (!reset_n)
    (bridge9_high_open_det && bridge9_low_open_det)
      |=> (open_load_status_upper[BRIDGE9_HIGH]
           && open_load_status_upper[BRIDGE9_LOW]))
    else $error("Bridge 9 flag not at its bit");

  a_read_clears: assert property ( // R6
    @(posedge clock) disable iff (!reset_n)
    // Quiet detectors are needed in the cycle the clear is applied
    (frame_end && addr_hit_r && bit_cnt_r == CNT_FRAME_DONE)
      ##1 (det_vec == 8'h00)
      |=> ((open_load_status_upper & $past(snap_r, 2)) == 8'h00))
    else $error("Complete read did not clear the read flags");

endmodule : olsb_status_upper

// ===== verif/olsb_host_model.sv
`timescale 1ns/1ps
module olsb_host_model (
  input  wire logic clock,
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_sdi,
  input  wire logic spi_sdo,
  input  wire logic spi_sdo_oe
);
  // Clocks per serial clock phase, above the four the device needs
  localparam int PHASE = 5;

  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi  = 1'b1;
  end

  // A count below sixteen aborts the frame early
  task automatic transfer(input logic [15:0] tx, input int rises,
                          output logic [15:0] rx, output logic oe_seen);
    rx = 16'h0000;
    @(posedge clock) spi_cs_n <= 1'b0;
    repeat (PHASE) @(posedge clock);
    oe_seen = spi_sdo_oe;
    for (int i = 15; i >= 16 - rises; i--) begin
      spi_sdi <= tx[i];
      repeat (PHASE) @(posedge clock);
      rx[i] = spi_sdo;
      spi_sclk <= 1'b1;
      repeat (PHASE) @(posedge clock);
      spi_sclk <= 1'b0;
    end
    repeat (PHASE) @(posedge clock);
    spi_cs_n <= 1'b1;
    // Released data line shows a changed level, not the last bit
    spi_sdi  <= ~spi_sdi;
    repeat (PHASE) @(posedge clock);
  endtask : transfer
endmodule : olsb_host_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import olsb_pkg::*;
  logic        clock;
  logic        reset_n;
  wire         spi_cs_n;
  wire         spi_sclk;
  wire         spi_sdi;
  logic        sdo;
  logic        oe;
  logic        oe_seen;
  olsb_byte_t  det;
  olsb_byte_t  flags;
  logic [15:0] rx;
  int          mismatches;
  int          total_checks;
  localparam logic [31:0] KINDS = {8'ha7, 8'h27, 8'ha5, 8'h25};

  olsb_status_upper uut (
    .clock(clock), .reset_n(reset_n), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo_out_r(sdo),
    .spi_sdo_oe_r(oe),
    .bridge12_high_open_det(det[7]), .bridge12_low_open_det(det[6]),
    .bridge11_high_open_det(det[5]), .bridge11_low_open_det(det[4]),
    .bridge10_high_open_det(det[3]), .bridge10_low_open_det(det[2]),
    .bridge9_high_open_det(det[1]), .bridge9_low_open_det(det[0]),
    .open_load_status_upper(flags)
  );

  olsb_host_model host (
    .clock(clock), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi), .spi_sdo(sdo), .spi_sdo_oe(oe)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    @(negedge clock);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic pulse(input olsb_byte_t bits);
    @(posedge clock) det <= bits;
    @(posedge clock) det <= 8'h00;
    // Flags are settled by the falling edge
    @(negedge clock);
  endtask : pulse

  // Clear lands a few clocks after chip select rises
  task automatic read_reg(input olsb_byte_t addr, input int rises,
                          input olsb_byte_t first, data);
    host.transfer({addr, 8'h00}, rises, rx, oe_seen);
    check("sdo_oe_off", {15'h0, oe}, 16'h0000);
    check("sdo_oe", {15'h0, oe_seen}, 16'h0001);
    if (rises == 16) check("frame", rx, {first, data});
    repeat (8) @(posedge clock);
  endtask : read_reg

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    reset_n = 1'b0;
    det = 8'h00;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    repeat (6) @(posedge clock);
    check("flags", {8'h00, flags}, {8'h00, STATUS_RESET});
    check("oe", {15'h0, oe}, 16'h0000);
    read_reg(8'h25, 16, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      check("flags", {8'h00, flags}, {8'h00, 8'h01 << i});
      read_reg(KINDS[(i % 4) * 8 +: 8], 16, 8'h80, 8'h01 << i);
      check("flags", {8'h00, flags}, 16'h0000);
    end
    pulse(8'h81);
    read_reg(8'h24, 16, 8'h80, 8'h00);
    read_reg(8'h2d, 16, 8'h80, 8'h00);
    read_reg(8'h25, 12, 8'h00, 8'h00);
    repeat (40) @(posedge clock);
    check("flags", {8'h00, flags}, 16'h0081);
    // A detection after the snapshot must survive the clear
    fork
      read_reg(8'h25, 16, 8'h80, 8'h81);
      begin
        repeat (130) @(posedge clock);
        pulse(8'h10);
        // Lands in the very cycle in which the clear is applied
        repeat (42) @(posedge clock);
        pulse(8'h01);
      end
    join
    check("flags", {8'h00, flags}, 16'h0011);
    pulse(8'hff);
    check("flags", {8'h00, flags}, {8'h00, PRESENT_MASK});
    @(posedge clock) reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    check("flags", {8'h00, flags}, 16'h0000);
    @(posedge clock) reset_n <= 1'b1;
    repeat (6) @(posedge clock);
    read_reg(8'ha7, 16, 8'h00, 8'h00);
    tally_and_finish();
  end
endmodule : testbench
